// ---- verilog/plcgf_pkg.sv ----
// Shared constants and types for the scan-cycle flag and gate engine.
// Assumes one 20 MHz clock and a plain register port on the same clock.
package plcgf_pkg;

    // Clock and program cycle timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SCAN_TIME_US  = 100;
    localparam int unsigned SCAN_CYCLES   = (SCAN_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SCAN_CNT_W    = 16;

    // Cell counts and widths
    localparam int unsigned NUM_DCELL     = 32;
    localparam int unsigned NUM_ACELL     = 256;
    localparam int unsigned NUM_RETAIN    = 64;
    localparam int unsigned ACELL_W       = 16;
    localparam int unsigned ACELL_IW      = 8;
    localparam int unsigned RETAIN_IW     = 6;
    localparam int unsigned STARTUP_CELL  = 7;
    localparam logic [7:0]  RETAIN_FIRST  = 8'h40;
    localparam logic [7:0]  LAST_ACELL    = 8'hFF;
    localparam logic [31:0] DOUT_RESET    = 32'h0000_0080;

    // Gates
    localparam int unsigned NUM_GATES     = 4;
    localparam int unsigned GATE_INS      = 4;

    // Register port map
    localparam int unsigned ADDR_W        = 12;
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_DCONN     = 12'h004;
    localparam logic [11:0] OFS_DCELL     = 12'h008;
    localparam logic [11:0] OFS_DOUT      = 12'h00C;
    localparam logic [11:0] OFS_ACFG      = 12'h010;
    localparam logic [7:0]  GATE_PAGE     = 8'h02;
    localparam logic [1:0]  REGION_REG    = 2'h0;
    localparam logic [1:0]  REGION_LIVE   = 2'h1;
    localparam logic [1:0]  REGION_START  = 2'h2;

    // Field positions
    localparam int unsigned ST_FIRST_BIT  = 0;
    localparam int unsigned ST_LINK_BIT   = 1;
    localparam int unsigned ST_BUSY_BIT   = 2;
    localparam int unsigned ACFG_CONN_BIT = 8;
    localparam int unsigned ACFG_START_BIT = 9;

    typedef enum logic [1:0] {
        GATE_AND      = 2'h0,
        GATE_AND_EDGE = 2'h1,
        GATE_NAND     = 2'h2
    } plcgf_gate_kind_type;

    typedef struct packed {
        plcgf_gate_kind_type    kind;
        logic [GATE_INS-1:0]    inv;
        logic [GATE_INS-1:0]    used;
    } plcgf_gate_cfg_type;

    typedef struct packed {
        logic [ACELL_IW-1:0]    idx;
        logic [ACELL_W-1:0]     data;
    } plcgf_awr_type;

    typedef enum logic [1:0] {
        SW_INIT = 2'h0,
        SW_IDLE = 2'h1,
        SW_COPY = 2'h2
    } plcgf_sweep_type;

endpackage

// ---- verilog/plcgf_cell_ram.sv ----
// Small memory: one write port, two read ports with registered data.
// Assumes a single clock; contents are not reset, so they survive srst.
`timescale 1ns/100ps
module plcgf_cell_ram #(
    parameter int unsigned W  = 16,
    parameter int unsigned D  = 256,
    parameter int unsigned AW = 8
) (
    // Clock
    input  wire logic          clk_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    // Read ports
    input  wire logic [AW-1:0] ra_addr_i,
    output logic      [W-1:0]  ra_data_o,
    input  wire logic [AW-1:0] rb_addr_i,
    output logic      [W-1:0]  rb_data_o
);

    logic [W-1:0] mem_q [D];

    // Write and registered reads; read-before-write on a clash
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
        ra_data_o <= mem_q[ra_addr_i];
        rb_data_o <= mem_q[rb_addr_i];
    end

endmodule // plcgf_cell_ram

// ---- verilog/plcgf_core.sv ----
// Scan-cycle engine: digital and analog mailbox cells, startup pulse, gates.
// Assumes local program and field-bus logic share clk_i; no pin inputs.
//
// Contract
// - Each digital cell holds one bit readable and writable locally and remotely.
// - Each analog cell holds a signed 16-bit value shared with remote side.
// - Thirty-two digital cells exist, each with its own fixed number.
// - Cell outputs show previous cycle value and hold while link has failed; startup cell still takes its live value as first cycle ends.
// - Startup cell is one during first program cycle, then ordinary cell.
// - Digital cell takes remote writes only while its input is unconnected.
// - Analog cell takes remote writes only while its input is unconnected.
// - Analog cells 1 to 64 have start value and keep contents over reset.
// - Analog cells 65 to 256 have no start value and clear on reset.
// - Connecting an analog cell input disables its start value option.
// - Every gate input can be inverted individually before evaluation.
// - AND gate gives one only when all inputs are one.
// - Edge AND gives one when all inputs one now, not all before.
// - Edge AND output lasts one cycle, then at least one low cycle.
// - NAND gate gives zero only when all inputs are one.
// - Outputs show previous cycle result and stay constant within a cycle.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module plcgf_core #(
    parameter int unsigned SCAN_CYCLES = plcgf_pkg::SCAN_CYCLES,
    parameter int unsigned NUM_GATES   = plcgf_pkg::NUM_GATES
) (
    // Clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           srst_i,
    // Register port
    input  wire logic [plcgf_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [31:0]                    reg_wdata_i,
    input  wire logic                           reg_we_i,
    input  wire logic                           reg_re_i,
    output logic      [31:0]                    reg_rdata_o,
    // Field-bus link state
    input  wire logic                           link_ok_i,
    // Local program side
    input  wire logic [plcgf_pkg::NUM_DCELL-1:0] dcell_in_i,
    input  wire logic                           awr_valid_i,
    input  wire plcgf_pkg::plcgf_awr_type       awr_i,
    output logic                                awr_ack_o,
    input  wire logic [plcgf_pkg::ACELL_IW-1:0] ard_idx_i,
    output logic      [plcgf_pkg::ACELL_W-1:0]  ard_data_o,
    input  wire logic [NUM_GATES*plcgf_pkg::GATE_INS-1:0] gate_in_i,
    // Program cycle results
    output logic      [NUM_GATES-1:0]           gate_q_o,
    output logic      [plcgf_pkg::NUM_DCELL-1:0] dcell_out_o,
    output logic                                first_scan_pulse_o,
    output logic                                scan_tick_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    localparam logic [31:0] STARTUP_MASK = 32'h1 << plcgf_pkg::STARTUP_CELL;

    // Decode of the register port
    logic [1:0] region;
    logic [7:0] bidx;
    logic       bw_live;
    logic       bw_start;
    assign region   = reg_addr_i[11:10];
    assign bidx     = reg_addr_i[9:2];
    assign bw_live  = reg_we_i && (region == plcgf_pkg::REGION_LIVE);
    assign bw_start = reg_we_i && (region == plcgf_pkg::REGION_START)
                      && (bidx < plcgf_pkg::RETAIN_FIRST);

    // State
    logic [31:0] dconn_q, dconn_d, dlive_q, dlive_d, dout_q, dout_d;
    logic        first_q, first_d, started_q, started_d, tick, tick_q;
    logic [plcgf_pkg::SCAN_CNT_W-1:0] scan_cnt_q, scan_cnt_d;
    logic [plcgf_pkg::NUM_ACELL-1:0]  conn_q, conn_d;
    logic [plcgf_pkg::NUM_RETAIN-1:0] start_en_q, start_en_d;
    logic [9:0]  acfg_q, acfg_d;
    plcgf_pkg::plcgf_gate_cfg_type gcfg_q [NUM_GATES];
    plcgf_pkg::plcgf_gate_cfg_type gcfg_d [NUM_GATES];
    plcgf_pkg::plcgf_sweep_type    sw_state_q, sw_state_d;
    logic [7:0]  sw_idx_q, sw_idx_d, sw_widx_q, sw_widx_d;
    logic        sw_wr_q, sw_wr_d;
    logic [1:0]  rd_sel_q, rd_sel_d;
    logic [31:0] rd_reg_q, rd_reg_d;
    logic        ack_d;

    // Memory ports
    logic        live_we;
    logic [7:0]  live_waddr;
    logic [15:0] live_wdata, live_ra, live_rb, start_rb;

    // Live cell write arbitration: reset clearing, then remote, then local
    always_comb
    begin
        live_we    = 1'b0;
        live_waddr = sw_idx_q;
        live_wdata = 16'h0000;
        ack_d      = 1'b0;
        if (sw_state_q == plcgf_pkg::SW_INIT)
        begin
            live_we = 1'b1;
        end
        else if (bw_live && !conn_q[bidx])
        begin
            live_we    = 1'b1;
            live_waddr = bidx;
            live_wdata = reg_wdata_i[15:0];
        end
        else if (bw_start && !conn_q[bidx] && start_en_q[bidx[5:0]])
        begin
            live_we    = 1'b1;
            live_waddr = bidx;
            live_wdata = reg_wdata_i[15:0];
        end
        else if (awr_valid_i && conn_q[awr_i.idx])
        begin
            live_we    = 1'b1;
            live_waddr = awr_i.idx;
            live_wdata = awr_i.data;
            ack_d      = 1'b1;
        end
    end

    // Live values, read by the copy sweep and by the register port
    plcgf_cell_ram #(.W(plcgf_pkg::ACELL_W), .D(plcgf_pkg::NUM_ACELL),
                     .AW(plcgf_pkg::ACELL_IW)) u_live (
        .clk_i     (clk_i),
        .we_i      (live_we),
        .waddr_i   (live_waddr),
        .wdata_i   (live_wdata),
        .ra_addr_i (sw_idx_q),
        .ra_data_o (live_ra),
        .rb_addr_i (bidx),
        .rb_data_o (live_rb)
    );

    // Previous-cycle snapshot that the local program reads
    plcgf_cell_ram #(.W(plcgf_pkg::ACELL_W), .D(plcgf_pkg::NUM_ACELL),
                     .AW(plcgf_pkg::ACELL_IW)) u_shadow (
        .clk_i     (clk_i),
        .we_i      (sw_wr_q),
        .waddr_i   (sw_widx_q),
        .wdata_i   (live_ra),
        .ra_addr_i (ard_idx_i),
        .ra_data_o (ard_data_o),
        .rb_addr_i (sw_widx_q),
        .rb_data_o ()
    );

    // Start values, only for the retained cells; refused once connected
    plcgf_cell_ram #(.W(plcgf_pkg::ACELL_W), .D(plcgf_pkg::NUM_RETAIN),
                     .AW(plcgf_pkg::RETAIN_IW)) u_start (
        .clk_i     (clk_i),
        .we_i      (bw_start && !conn_q[bidx]),
        .waddr_i   (bidx[5:0]),
        .wdata_i   (reg_wdata_i[15:0]),
        .ra_addr_i (bidx[5:0]),
        .ra_data_o (start_rb),
        .rb_addr_i (bidx[5:0]),
        .rb_data_o ()
    );

    // Program-cycle timer and snapshot sweep; a sweep is short of a cycle
    always_comb
    begin
        tick       = (sw_state_q != plcgf_pkg::SW_INIT) && (scan_cnt_q == '0);
        scan_cnt_d = scan_cnt_q;
        sw_state_d = sw_state_q;
        sw_idx_d   = sw_idx_q;
        sw_wr_d    = 1'b0;
        sw_widx_d  = sw_idx_q;
        if (sw_state_q != plcgf_pkg::SW_INIT)
        begin
            scan_cnt_d = tick ? plcgf_pkg::SCAN_CNT_W'(SCAN_CYCLES - 1)
                              : scan_cnt_q - 1'b1;
        end
        unique case (sw_state_q)
            plcgf_pkg::SW_INIT:
            begin
                sw_idx_d = sw_idx_q + 1'b1;
                if (sw_idx_q == plcgf_pkg::LAST_ACELL)
                begin
                    sw_state_d = plcgf_pkg::SW_IDLE;
                end
            end
            plcgf_pkg::SW_IDLE:
            begin
                sw_idx_d = 8'h00;
                if (tick && link_ok_i)
                begin
                    sw_state_d = plcgf_pkg::SW_COPY;
                end
            end
            plcgf_pkg::SW_COPY:
            begin
                sw_wr_d  = 1'b1;
                sw_idx_d = sw_idx_q + 1'b1;
                if (sw_idx_q == plcgf_pkg::LAST_ACELL)
                begin
                    sw_state_d = plcgf_pkg::SW_IDLE;
                end
            end
            default:
            begin
                sw_state_d = plcgf_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            scan_cnt_q <= '0;
            sw_state_q <= plcgf_pkg::SW_INIT;
            sw_idx_q   <= plcgf_pkg::RETAIN_FIRST;
            sw_wr_q    <= 1'b0;
            sw_widx_q  <= 8'h00;
            tick_q     <= 1'b0;
        end
        else
        begin
            scan_cnt_q <= scan_cnt_d;
            sw_state_q <= sw_state_d;
            sw_idx_q   <= sw_idx_d;
            sw_wr_q    <= sw_wr_d;
            sw_widx_q  <= sw_widx_d;
            tick_q     <= tick;
        end
    end

    // Register writes, digital cells and analog cell configuration
    always_comb
    begin
        dconn_d    = dconn_q;
        conn_d     = conn_q;
        start_en_d = start_en_q;
        acfg_d     = acfg_q;
        gcfg_d     = gcfg_q;
        dlive_d    = (dlive_q & ~dconn_q) | (dcell_in_i & dconn_q);
        if (reg_we_i && (reg_addr_i == plcgf_pkg::OFS_DCONN))
        begin
            dconn_d = reg_wdata_i;
        end
        if (reg_we_i && (reg_addr_i == plcgf_pkg::OFS_DCELL))
        begin
            dlive_d = (dlive_d & dconn_q) | (reg_wdata_i & ~dconn_q);
        end
        if (reg_we_i && (reg_addr_i == plcgf_pkg::OFS_ACFG))
        begin
            conn_d[reg_wdata_i[7:0]] = reg_wdata_i[plcgf_pkg::ACFG_CONN_BIT];
            acfg_d = {reg_wdata_i[plcgf_pkg::ACFG_START_BIT]
                      & ~reg_wdata_i[plcgf_pkg::ACFG_CONN_BIT],
                      reg_wdata_i[8:0]};
            if (reg_wdata_i[7:0] < plcgf_pkg::RETAIN_FIRST)
            begin
                start_en_d[reg_wdata_i[5:0]] = acfg_d[plcgf_pkg::ACFG_START_BIT];
            end
        end
        if (reg_we_i && (region == plcgf_pkg::REGION_REG)
            && (reg_addr_i[11:4] == plcgf_pkg::GATE_PAGE))
        begin
            gcfg_d[reg_addr_i[3:2]] = reg_wdata_i[9:0];
        end
    end

    // Register read data; narrow values sit in the low bits
    always_comb
    begin
        rd_sel_d = plcgf_pkg::REGION_REG;
        rd_reg_d = 32'h0000_0000;
        if ((region == plcgf_pkg::REGION_LIVE) || bw_start || (reg_re_i
            && (region == plcgf_pkg::REGION_START) && (bidx < plcgf_pkg::RETAIN_FIRST)))
        begin
            rd_sel_d = region;
        end
        else if (region == plcgf_pkg::REGION_REG)
        begin
            unique case (reg_addr_i)
                plcgf_pkg::OFS_STATUS: rd_reg_d = {29'h0,
                    sw_state_q != plcgf_pkg::SW_IDLE, link_ok_i, first_q};
                plcgf_pkg::OFS_DCONN:  rd_reg_d = dconn_q;
                plcgf_pkg::OFS_DCELL:  rd_reg_d = dlive_q;
                plcgf_pkg::OFS_DOUT:   rd_reg_d = dout_q;
                plcgf_pkg::OFS_ACFG:   rd_reg_d = {22'h0, acfg_q};
                default:
                begin
                    if (reg_addr_i[11:4] == plcgf_pkg::GATE_PAGE)
                    begin
                        rd_reg_d = {22'h0, gcfg_q[reg_addr_i[3:2]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dconn_q    <= 32'h0000_0000;
            dlive_q    <= 32'h0000_0000;
            conn_q     <= '0;
            start_en_q <= '0;
            acfg_q     <= 10'h000;
            gcfg_q     <= '{default: '0};
            rd_sel_q   <= plcgf_pkg::REGION_REG;
            rd_reg_q   <= 32'h0000_0000;
            awr_ack_o  <= 1'b0;
        end
        else
        begin
            dconn_q    <= dconn_d;
            dlive_q    <= dlive_d;
            conn_q     <= conn_d;
            start_en_q <= start_en_d;
            acfg_q     <= acfg_d;
            gcfg_q     <= gcfg_d;
            rd_sel_q   <= rd_sel_d;
            rd_reg_q   <= rd_reg_d;
            awr_ack_o  <= ack_d;
        end
    end

    // Memory data is already registered, so only a select follows it
    assign reg_rdata_o = (rd_sel_q == plcgf_pkg::REGION_LIVE)  ? {16'h0, live_rb}  :
                         (rd_sel_q == plcgf_pkg::REGION_START) ? {16'h0, start_rb} :
                         rd_reg_q;

    // Digital outputs and startup pulse, moved only on the cycle tick
    always_comb
    begin
        dout_d    = dout_q;
        first_d   = first_q;
        started_d = started_q;
        if (tick)
        begin
            if (link_ok_i)
            begin
                dout_d = dlive_q;
            end
            started_d = 1'b1;
            first_d   = !started_q;
            dout_d[plcgf_pkg::STARTUP_CELL] = !started_q
                || (link_ok_i || first_q ? dlive_q[plcgf_pkg::STARTUP_CELL]
                                         : dout_q[plcgf_pkg::STARTUP_CELL]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dout_q    <= plcgf_pkg::DOUT_RESET;
            first_q   <= 1'b1;
            started_q <= 1'b0;
        end
        else
        begin
            dout_q    <= dout_d;
            first_q   <= first_d;
            started_q <= started_d;
        end
    end

    assign dcell_out_o        = dout_q;
    assign first_scan_pulse_o = first_q;
    assign scan_tick_o        = tick_q;

    // Gates; prior all-ones starts high so no edge AND fires on the first cycle
    for (genvar g = 0; g < NUM_GATES; g++)
    begin : g_gate
        logic [plcgf_pkg::GATE_INS-1:0] eff;
        logic all_one, out_q, out_d, prev_q, prev_d;
        assign eff = (gate_in_i[g*plcgf_pkg::GATE_INS +: plcgf_pkg::GATE_INS]
                      ^ gcfg_q[g].inv) | ~gcfg_q[g].used;
        assign all_one = &eff;

        always_comb
        begin
            out_d  = out_q;
            prev_d = prev_q;
            if (tick)
            begin
                prev_d = all_one;
                unique case (gcfg_q[g].kind)
                    plcgf_pkg::GATE_AND:      out_d = all_one;
                    plcgf_pkg::GATE_AND_EDGE: out_d = all_one && !prev_q;
                    plcgf_pkg::GATE_NAND:     out_d = !all_one;
                    default:                  out_d = 1'b0;
                endcase
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (srst_i)
            begin
                out_q  <= 1'b0;
                prev_q <= 1'b1;
            end
            else
            begin
                out_q  <= out_d;
                prev_q <= prev_d;
            end
        end
        assign gate_q_o[g] = out_q;

        a_gate_and_val: assert property (tick && gcfg_q[g].kind == plcgf_pkg::GATE_AND
            |=> gate_q_o[g] == &$past(eff)) else $error("AND gate result wrong");
        a_gate_nand_val: assert property (tick && gcfg_q[g].kind == plcgf_pkg::GATE_NAND
            |=> gate_q_o[g] != &$past(eff)) else $error("NAND gate result wrong");
        a_edge_one_cycle: assert property (tick && gate_q_o[g] && gcfg_q[g].kind
            == plcgf_pkg::GATE_AND_EDGE && $stable(gcfg_q[g]) |=> !gate_q_o[g])
            else $error("Edge AND high for two cycles");
        a_gate_steady: assert property (!tick |=> $stable(gate_q_o[g]))
            else $error("Gate output moved inside a cycle");
    end

    a_dout_prev: assert property (tick && link_ok_i && started_q && !first_q
        |=> dcell_out_o == $past(dlive_q)) else $error("Cell output not last cycle value");
    a_dout_hold: assert property (tick && !link_ok_i
        |=> ((dcell_out_o ^ $past(dcell_out_o)) & ~STARTUP_MASK) == 32'h0)
        else $error("Cell output changed while link failed");
    a_dout_steady: assert property (!tick |=> $stable(dcell_out_o))
        else $error("Cell output moved inside a cycle");
    a_startup_set: assert property (tick && !started_q
        |=> first_scan_pulse_o && dcell_out_o[plcgf_pkg::STARTUP_CELL])
        else $error("Startup cell not set in first cycle");
    a_startup_clear: assert property (tick && started_q |=> !first_scan_pulse_o)
        else $error("Startup flag still set after first cycle");
    a_dremote_mask: assert property (reg_we_i && reg_addr_i == plcgf_pkg::OFS_DCELL
        |=> ((dlive_q ^ $past(reg_wdata_i)) & ~$past(dconn_q)) == 32'h0)
        else $error("Remote write to free digital cell lost");
    a_dlocal_follow: assert property (##1 1'b1
        |-> ((dlive_q ^ $past(dcell_in_i)) & $past(dconn_q)) == 32'h0)
        else $error("Connected digital cell not following input");
    a_astart_off: assert property ((conn_q[plcgf_pkg::NUM_RETAIN-1:0] & start_en_q) == '0)
        else $error("Start value enabled on connected cell");
    a_init_range: assert property (sw_state_q == plcgf_pkg::SW_INIT
        |-> sw_idx_q >= plcgf_pkg::RETAIN_FIRST) else $error("Reset clearing hit retained cell");
    a_awr_refuse: assert property (awr_valid_i && !conn_q[awr_i.idx] |=> !awr_ack_o)
        else $error("Local write accepted on free analog cell");

endmodule // plcgf_core

// ---- verif/plcgf_remote.sv ----
// Remote field-bus master model driving the register port.
// Assumes clk_i is the core clock; strobes change after rising edges.
`timescale 1ns/100ps
module plcgf_remote (
    // Clock
    input  wire logic        clk_i,
    // Register port, master side
    output logic [11:0]      ra_o,
    output logic [31:0]      wd_o,
    output logic             we_o,
    output logic             re_o,
    input  wire logic [31:0] rd_i
);
    // Idle bus at time zero
    initial
    begin
        ra_o = 12'h000;
        wd_o = 32'h0000_0000;
        we_o = 1'b0;
        re_o = 1'b0;
    end
    // Released lines show inverted values so stale data never passes
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        ra_o <= a;
        wd_o <= d;
        we_o <= 1'b1;
        @(posedge clk_i);
        we_o <= 1'b0;
        ra_o <= ~a;
        wd_o <= ~d;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        ra_o <= a;
        re_o <= 1'b1;
        @(posedge clk_i);
        re_o <= 1'b0;
        ra_o <= ~a;
        @(negedge clk_i);
        d = rd_i;
    endtask
endmodule // plcgf_remote

// ---- verif/testbench.sv ----
// Self-checking bench for the scan-cycle flag and gate engine.
// Assumes plcgf_remote masters the register port; short program cycle.
`timescale 1ns/100ps
module testbench;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        link = 1'b1;
    logic [31:0] din = 32'h0000_0000;
    logic [15:0] gin = 16'h0000;
    logic [11:0] ra;
    logic [31:0] wd, rd, dout;
    logic        we, re, fsp, tick;
    logic [3:0]  gq;
    logic        awv = 1'b0;
    logic        ack;
    logic [7:0]  aidx = 8'h46;
    logic [15:0] ard;
    plcgf_pkg::plcgf_awr_type awd = '0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    // Local analog reads watch cell 70 only; local writes come from lwr
    plcgf_core #(.SCAN_CYCLES(300), .NUM_GATES(4)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(ra), .reg_wdata_i(wd),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .link_ok_i(link),
        .dcell_in_i(din), .awr_valid_i(awv), .awr_i(awd), .awr_ack_o(ack),
        .ard_idx_i(aidx), .ard_data_o(ard), .gate_in_i(gin), .gate_q_o(gq),
        .dcell_out_o(dout), .first_scan_pulse_o(fsp), .scan_tick_o(tick));
    plcgf_remote remote (.clk_i(clk_i), .ra_o(ra), .wd_o(wd), .we_o(we),
        .re_o(re), .rd_i(rd));
    // 20 MHz clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        $display("TB: compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        remote.rd(a, d);
        chk(d, e);
    endtask
    // Local analog write; the acknowledge stands in the cycle after the strobe
    task automatic lwr(input logic [7:0] i, input logic [15:0] v, output logic a);
        @(posedge clk_i);
        awv <= 1'b1;
        awd <= {i, v};
        @(posedge clk_i);
        awv <= 1'b0;
        @(negedge clk_i);
        a = ack;
    endtask
    // Bounded wait for the next output update, sampled mid-cycle
    task automatic wait_tick();
        int n;
        n = 0;
        @(negedge clk_i);
        while (tick !== 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, tick}, 32'h1);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (15) @(posedge clk_i);
        srst_i <= 1'b0;
    endtask
    task automatic t_first();
        wait_tick();
        chk({31'h0, fsp}, 32'h1);
        chk({31'h0, dout[7]}, 32'h1);
        wait_tick();
        chk({31'h0, fsp}, 32'h0);
        chk({31'h0, dout[7]}, 32'h0);
        $display("TB: first cycle test done");
    endtask
    // Two ticks after a write, since the write may straddle one
    task automatic t_dig();
        remote.wr(12'h004, 32'h0000_0000);
        remote.wr(12'h008, 32'hA5A5_0F0F);
        wait_tick();
        wait_tick();
        chk(dout, 32'hA5A5_0F0F);
        @(posedge clk_i);
        link <= 1'b0;
        remote.wr(12'h008, 32'h1234_5678);
        wait_tick();
        wait_tick();
        chk(dout, 32'hA5A5_0F0F);
        rc(12'h008, 32'h1234_5678);
        @(posedge clk_i);
        link <= 1'b1;
        din <= 32'hFFFF_0000;
        remote.wr(12'h004, 32'h00FF_00FF);
        remote.wr(12'h008, 32'h0000_0000);
        wait_tick();
        wait_tick();
        chk(dout, 32'h00FF_0000);
        $display("TB: digital cell test done");
    endtask
    // Gates: AND, edge AND, NAND, AND with one inverted and two unused
    task automatic t_gate();
        logic [15:0] p [5] = '{16'h0000, 16'h2FFF, 16'h2FFF, 16'h3E70, 16'h2FFF};
        logic [3:0]  q [5] = '{4'h4, 4'hB, 4'h9, 4'h4, 4'hB};
        remote.wr(12'h020, 32'h0000_000F);
        remote.wr(12'h024, 32'h0000_010F);
        remote.wr(12'h028, 32'h0000_020F);
        remote.wr(12'h02C, 32'h0000_0013);
        wait_tick();
        foreach (p[i])
        begin
            @(posedge clk_i);
            gin <= p[i];
            wait_tick();
            chk({28'h0, gq}, {28'h0, q[i]});
            repeat (150) @(negedge clk_i);
            chk({28'h0, gq}, {28'h0, q[i]});
        end
        // Kind code 3 forces gate 3 low; edge gate stays low on held inputs
        remote.wr(12'h02C, 32'h0000_0313);
        wait_tick();
        wait_tick();
        chk({28'h0, gq}, 32'h0000_0001);
        $display("TB: gate test done");
    endtask
    task automatic t_ana();
        logic a;
        remote.wr(12'h518, 32'h0000_8001);
        rc(12'h518, 32'h0000_8001);
        remote.wr(12'h010, 32'h0000_0146);
        remote.wr(12'h518, 32'h0000_1111);
        rc(12'h518, 32'h0000_8001);
        lwr(8'h46, 16'h2222, a);
        chk({31'h0, a}, 32'h1);
        lwr(8'h03, 16'h5555, a);
        chk({31'h0, a}, 32'h0);
        rc(12'h518, 32'h0000_2222);
        wait_tick();
        wait_tick();
        chk({16'h0, ard}, 32'h0000_2222);
        remote.wr(12'h010, 32'h0000_0305);
        rc(12'h010, 32'h0000_0105);
        remote.wr(12'h010, 32'h0000_0203);
        remote.wr(12'h80C, 32'h0000_1234);
        rc(12'h40C, 32'h0000_1234);
        rc(12'hC00, 32'h0000_0000);
        do_reset();
        wait_tick();
        rc(12'h40C, 32'h0000_1234);
        rc(12'h518, 32'h0000_0000);
        $display("TB: analog cell test done");
    endtask
    // Main sequence; the analog test resets, so it runs last
    initial
    begin
        do_reset();
        t_first();
        t_dig();
        t_gate();
        t_ana();
        report_and_stop();
    end
    // Watchdog well past the roughly 5600 cycles the tests take
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end
endmodule // testbench
